/* hw/dmx_consts.svh */
`ifndef DMX_CONSTS_SVH
`define DMX_CONSTS_SVH

// ----------------------------------------------------------------
// Register map on the configuration port (byte addresses).
// ----------------------------------------------------------------
`define DMX_PSW_ADDR 8'hD0
`define DMX_AUXILIARY_CONTROL_REGISTER_ADDR 8'h8E
`define DMX_HPL_ADDR 8'hA0
`define DMX_STAT_ADDR 8'hF0

// ----------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------
`define DMX_PSW_BANK_LO 3
`define DMX_PSW_BANK_HI 4
`define DMX_AUXILIARY_CONTROL_REGISTER_XDIS 1
`define DMX_AUXILIARY_CONTROL_REGISTER_XRS_LO 2
`define DMX_AUXILIARY_CONTROL_REGISTER_XRS_HI 3
`define DMX_AUXILIARY_CONTROL_REGISTER_STRETCH 5
`define DMX_PSW_RESET 8'h00
`define DMX_XRS_RESET 2'h3
`define DMX_HPL_RESET 8'hFF

// ----------------------------------------------------------------
// Memory map.
// ----------------------------------------------------------------
`define DMX_BITAREA_BASE 8'h20
`define DMX_EXPANDED_RAM_BYTES 1024
`define DMX_EXPANDED_RAM_PAGE 256

// ----------------------------------------------------------------
// External cycle timing, counted in CPU clock periods.
// ----------------------------------------------------------------
`define DMX_EXT_ALE_PER 1
`define DMX_EXT_SETUP_PER 1
`define DMX_EXT_HOLD_PER 1
`define DMX_STB_NORMAL 3
`define DMX_STB_STRETCH 15

`endif

/* hw/dmx_extbus.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmx_consts.svh"

// Sequencer of one multiplexed external bus cycle.
module dmx_extbus (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cpu_ce,
	input wire logic start,
	input wire logic write,
	input wire logic stretch,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] idle_high,
	input wire logic [7:0] low_port_in,
	output logic [7:0] low_port_out,
	output logic low_port_oe,
	output logic [7:0] high_port_out,
	output logic ale,
	output logic rd_n,
	output logic wr_n,
	output logic done,
	output logic [7:0] rdata
);

	localparam logic [4:0] STB_BEGIN = 5'(`DMX_EXT_ALE_PER + `DMX_EXT_SETUP_PER);

	logic busy;
	logic wr_op;
	logic [4:0] per;
	logic [4:0] next_per;
	logic [4:0] stb_end;
	logic [4:0] cyc_end;

	assign next_per = per + 5'd1;
	// The strobe grows from 3 to 15 periods when stretching.
	assign stb_end = STB_BEGIN + (stretch ? 5'(`DMX_STB_STRETCH) : 5'(`DMX_STB_NORMAL));
	// Normal cycle totals 6 CPU periods.
	assign cyc_end = stb_end + 5'(`DMX_EXT_HOLD_PER);

	// ----------------------------------------------------------------
	// Cycle sequencer.
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy <= 1'b0;
			wr_op <= 1'b0;
			per <= 5'd0;
			low_port_out <= 8'h00;
			low_port_oe <= 1'b0;
			high_port_out <= `DMX_HPL_RESET;
			ale <= 1'b0;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			done <= 1'b0;
			rdata <= 8'h00;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				high_port_out <= idle_high; // Idle high port shows its latch.
				if (start) begin
					busy <= 1'b1;
					wr_op <= write;
					per <= 5'd0;
					ale <= 1'b1; // Low address valid while ALE is high.
					low_port_out <= addr[7:0];
					low_port_oe <= 1'b1;
					high_port_out <= addr[15:8];
				end
			end else if (cpu_ce) begin
				per <= next_per;
				if (next_per == 5'(`DMX_EXT_ALE_PER)) begin
					ale <= 1'b0;
				end
				if (next_per == STB_BEGIN) begin
					// Only one active-low strobe per transfer.
					rd_n <= wr_op;
					wr_n <= !wr_op;
					low_port_oe <= wr_op;
					if (wr_op) begin
						low_port_out <= wdata; // Data shares the low port.
					end
				end
				if (next_per == stb_end) begin
					rd_n <= 1'b1;
					wr_n <= 1'b1;
					if (!wr_op) begin
						rdata <= low_port_in;
					end
				end
				if (next_per == cyc_end) begin
					busy <= 1'b0;
					low_port_oe <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

endmodule : dmx_extbus

`default_nettype wire

/* hw/dmx_pkg.sv */
package dmx_pkg;

	// Kind of data memory access requested by the core.
	typedef enum logic [2:0] {
		KIND_DIRECT,
		KIND_INDIRECT,
		KIND_REG,
		KIND_BIT,
		KIND_MOVX_DPTR,
		KIND_MOVX_RI
	} dmx_kind_t;

	// Space that a decoded access lands in.
	typedef enum logic [1:0] {
		TGT_RAM,
		TGT_SFR,
		TGT_EXPANDED_RAM,
		TGT_EXT
	} dmx_tgt_t;

	// Sequencer states of the access controller.
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_EXT
	} dmx_state_t;

endpackage : dmx_pkg

/* hw/dmx_ram.sv */
`timescale 1ns/1ps
`default_nettype none

// Single-port byte memory with a registered read.
module dmx_ram #(
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);

	generate
		if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad_depth
			$error("dmx_ram depth does not fit the address width.");
		end
	endgenerate

	logic [7:0] mem [DEPTH];

	// Write and read share one port; a read returns the old byte.
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end

endmodule : dmx_ram

`default_nettype wire

/* hw/dmx_top.sv */
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dmx_consts.svh"

// Function
// - Lower RAM 00h-7Fh, direct and indirect.
// - Lowest 32 bytes form four 8-register banks.
// - Bank-select bits pick the working bank.
// - 16 bytes above banks are bit-addressable.
// - Upper RAM 80h-FFh, indirect only.
// - Direct 80h-FFh reaches special function registers.
// - Expanded RAM 0000h-03FFh via external moves.
// - Disable bit zero routes moves on-chip.
// - Size field limits expanded RAM, reset full.
// - High port address, low port address/data.
// - Address latch strobe marks valid low address.
// - Read and write strobes toward external memory.
// - Unstretched external cycle lasts six CPU periods.
// - Stretch bit widens strobes 3 to 15.
// - Register-indirect move drives latch on high port.

module dmx_top #(
	parameter int EXPANDED_RAM_DEPTH = `DMX_EXPANDED_RAM_BYTES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic double_speed_mode,
	input wire logic [7:0] cfg_addr,
	input wire logic [7:0] cfg_wdata,
	input wire logic cfg_we,
	input wire logic cfg_re,
	output logic [7:0] cfg_rdata,
	input wire logic mem_req,
	input wire logic [2:0] mem_kind,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic mem_busy,
	output logic mem_done,
	output logic [7:0] mem_rdata,
	output logic sfr_rd,
	output logic sfr_wr,
	output logic [7:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic [7:0] low_port_in,
	output logic [7:0] low_port_out,
	output logic low_port_oe,
	output logic [7:0] high_port_out,
	output logic ale,
	output logic rd_n,
	output logic wr_n
);

	generate
		if (EXPANDED_RAM_DEPTH < `DMX_EXPANDED_RAM_PAGE || EXPANDED_RAM_DEPTH > `DMX_EXPANDED_RAM_BYTES ||
			(EXPANDED_RAM_DEPTH % `DMX_EXPANDED_RAM_PAGE) != 0) begin : g_bad_expanded_ram
			$error("dmx_top expanded RAM depth must be whole pages up to 1024.");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Helper functions.
	// ----------------------------------------------------------------

	// Byte address of working register r in the selected bank.
	function automatic logic [7:0] bank_reg_addr(input logic [1:0] bank, input logic [2:0] r);
		bank_reg_addr = {3'b000, bank, r};
	endfunction : bank_reg_addr

	// True when an external-move address falls in the enabled on-chip RAM.
	function automatic logic expanded_ram_hit(input logic [15:0] a, input logic [1:0] size,
		input logic dis);
		logic [16:0] lim;
		lim = 17'(({15'd0, size} + 17'd1) * 17'(`DMX_EXPANDED_RAM_PAGE));
		if (lim > 17'(EXPANDED_RAM_DEPTH)) begin
			lim = 17'(EXPANDED_RAM_DEPTH);
		end
		expanded_ram_hit = !dis && ({1'b0, a} < lim);
	endfunction : expanded_ram_hit

	// ----------------------------------------------------------------
	// Configuration registers.
	// ----------------------------------------------------------------
	logic [7:0] program_status_word;
	logic strobe_stretch;
	logic [1:0] expanded_ram_size_field;
	logic internal_xmem_disable;
	logic [7:0] high_port_latch;
	logic last_ext;
	logic [1:0] bank_sel;

	// Bank select is the pair bank_select_high, bank_select_low.
	assign bank_sel = {program_status_word[`DMX_PSW_BANK_HI],
		program_status_word[`DMX_PSW_BANK_LO]};

	// Software writes of the control registers.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			program_status_word <= `DMX_PSW_RESET;
			strobe_stretch <= 1'b0;
			expanded_ram_size_field <= `DMX_XRS_RESET; // Full size after reset.
			internal_xmem_disable <= 1'b0; // On-chip RAM by default.
			high_port_latch <= `DMX_HPL_RESET;
		end else if (cfg_we) begin
			case (cfg_addr)
				`DMX_PSW_ADDR: begin
					program_status_word <= cfg_wdata;
				end
				`DMX_AUXILIARY_CONTROL_REGISTER_ADDR: begin
					strobe_stretch <= cfg_wdata[`DMX_AUXILIARY_CONTROL_REGISTER_STRETCH];
					expanded_ram_size_field <= cfg_wdata[`DMX_AUXILIARY_CONTROL_REGISTER_XRS_HI:`DMX_AUXILIARY_CONTROL_REGISTER_XRS_LO];
					internal_xmem_disable <= cfg_wdata[`DMX_AUXILIARY_CONTROL_REGISTER_XDIS];
				end
				`DMX_HPL_ADDR: begin
					high_port_latch <= cfg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// Read data stand in the cycle after the read strobe; unmapped reads give zero.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_rdata <= 8'h00;
		end else begin
			cfg_rdata <= 8'h00;
			if (cfg_re) begin
				case (cfg_addr)
					`DMX_PSW_ADDR: begin
						cfg_rdata <= program_status_word;
					end
					`DMX_AUXILIARY_CONTROL_REGISTER_ADDR: begin
						cfg_rdata[`DMX_AUXILIARY_CONTROL_REGISTER_STRETCH] <= strobe_stretch;
						cfg_rdata[`DMX_AUXILIARY_CONTROL_REGISTER_XRS_HI:`DMX_AUXILIARY_CONTROL_REGISTER_XRS_LO] <= expanded_ram_size_field;
						cfg_rdata[`DMX_AUXILIARY_CONTROL_REGISTER_XDIS] <= internal_xmem_disable;
					end
					`DMX_HPL_ADDR: begin
						cfg_rdata <= high_port_latch;
					end
					`DMX_STAT_ADDR: begin
						cfg_rdata <= {6'd0, last_ext, mem_busy};
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// CPU clock enable: every oscillator edge in double speed, else every other.
	// ----------------------------------------------------------------
	logic cpu_ce;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cpu_ce <= 1'b0;
		end else begin
			cpu_ce <= double_speed_mode ? 1'b1 : !cpu_ce;
		end
	end

	// ----------------------------------------------------------------
	// Address decode of a new request.
	// ----------------------------------------------------------------
	dmx_pkg::dmx_state_t state;
	dmx_pkg::dmx_kind_t kind_in;
	dmx_pkg::dmx_tgt_t dec_tgt;
	logic [7:0] dec_byte;
	logic [15:0] dec_xaddr;
	logic dec_bit;
	logic accept;

	assign kind_in = dmx_pkg::dmx_kind_t'(mem_kind);
	assign accept = mem_req && (state == dmx_pkg::ST_IDLE);

	// Map the request onto one of the four spaces.
	always_comb begin
		dec_tgt = dmx_pkg::TGT_RAM;
		dec_byte = mem_addr[7:0];
		dec_xaddr = mem_addr;
		dec_bit = 1'b0;
		case (kind_in)
			dmx_pkg::KIND_DIRECT: begin
				if (mem_addr[7]) begin
					dec_tgt = dmx_pkg::TGT_SFR;
				end
			end
			dmx_pkg::KIND_INDIRECT: begin
				dec_tgt = dmx_pkg::TGT_RAM; // Indirect reaches all 256 bytes.
			end
			dmx_pkg::KIND_REG: begin
				dec_byte = bank_reg_addr(bank_sel, mem_addr[2:0]);
			end
			dmx_pkg::KIND_BIT: begin
				dec_bit = 1'b1;
				if (mem_addr[7]) begin
					dec_tgt = dmx_pkg::TGT_SFR;
					dec_byte = {mem_addr[7:3], 3'b000};
				end else begin
					dec_byte = `DMX_BITAREA_BASE + {4'h0, mem_addr[6:3]};
				end
			end
			dmx_pkg::KIND_MOVX_DPTR, dmx_pkg::KIND_MOVX_RI: begin
				if (kind_in == dmx_pkg::KIND_MOVX_RI) begin
					dec_xaddr = {high_port_latch, mem_addr[7:0]};
				end
				// On-chip unless disabled or above the size limit.
				if (expanded_ram_hit(dec_xaddr, expanded_ram_size_field, internal_xmem_disable)) begin
					dec_tgt = dmx_pkg::TGT_EXPANDED_RAM;
				end else begin
					dec_tgt = dmx_pkg::TGT_EXT;
				end
			end
			default: begin
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer and held request.
	// ----------------------------------------------------------------
	dmx_pkg::dmx_tgt_t op_tgt;
	logic [7:0] op_byte;
	logic op_bit;
	logic op_we;
	logic [2:0] op_bitsel;
	logic op_bitval;
	logic [7:0] rd_byte;
	logic [7:0] mod_byte;
	logic ext_done;
	logic [7:0] ext_rdata;
	logic [7:0] ram_rdata;
	logic [7:0] expanded_ram_rdata;

	// Byte returned by the space that was read.
	always_comb begin
		case (op_tgt)
			dmx_pkg::TGT_SFR: rd_byte = sfr_rdata;
			dmx_pkg::TGT_EXPANDED_RAM: rd_byte = expanded_ram_rdata;
			default: rd_byte = ram_rdata;
		endcase
		mod_byte = rd_byte;
		mod_byte[op_bitsel] = op_bitval;
	end

	// Access sequencing; bit writes are read-modify-write.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= dmx_pkg::ST_IDLE;
			op_tgt <= dmx_pkg::TGT_RAM;
			op_byte <= 8'h00;
			op_bit <= 1'b0;
			op_we <= 1'b0;
			op_bitsel <= 3'd0;
			op_bitval <= 1'b0;
			mem_busy <= 1'b0;
			mem_done <= 1'b0;
			mem_rdata <= 8'h00;
			last_ext <= 1'b0;
		end else begin
			mem_done <= 1'b0;
			case (state)
				dmx_pkg::ST_IDLE: begin
					if (accept) begin
						op_tgt <= dec_tgt;
						op_byte <= dec_byte;
						op_bit <= dec_bit;
						op_we <= mem_we;
						op_bitsel <= mem_addr[2:0];
						op_bitval <= mem_wdata[0];
						last_ext <= (dec_tgt == dmx_pkg::TGT_EXT);
						if (dec_tgt == dmx_pkg::TGT_EXT) begin
							state <= dmx_pkg::ST_EXT;
							mem_busy <= 1'b1;
						end else if (mem_we && !dec_bit) begin
							mem_done <= 1'b1;
						end else begin
							state <= dmx_pkg::ST_READ;
							mem_busy <= 1'b1;
						end
					end
				end
				dmx_pkg::ST_READ: begin
					state <= dmx_pkg::ST_IDLE;
					mem_busy <= 1'b0;
					mem_done <= 1'b1;
					if (op_bit) begin
						mem_rdata <= {7'd0, rd_byte[op_bitsel]};
					end else begin
						mem_rdata <= rd_byte;
					end
				end
				dmx_pkg::ST_EXT: begin
					if (ext_done) begin
						state <= dmx_pkg::ST_IDLE;
						mem_busy <= 1'b0;
						mem_done <= 1'b1;
						if (!op_we) begin
							mem_rdata <= ext_rdata;
						end
					end
				end
				default: begin
					state <= dmx_pkg::ST_IDLE;
					mem_busy <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Special function register strobes.
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sfr_rd <= 1'b0;
			sfr_wr <= 1'b0;
			sfr_addr <= 8'h00;
			sfr_wdata <= 8'h00;
		end else begin
			sfr_rd <= 1'b0;
			sfr_wr <= 1'b0;
			if (accept && dec_tgt == dmx_pkg::TGT_SFR) begin
				sfr_addr <= dec_byte; // Direct upper half goes to the registers.
				sfr_rd <= !mem_we || dec_bit;
				sfr_wr <= mem_we && !dec_bit;
				sfr_wdata <= mem_wdata;
			end else if (state == dmx_pkg::ST_READ && op_tgt == dmx_pkg::TGT_SFR &&
				op_bit && op_we) begin
				sfr_wr <= 1'b1;
				sfr_wdata <= mod_byte;
			end
		end
	end

	// ----------------------------------------------------------------
	// Internal RAM and expanded RAM.
	// ----------------------------------------------------------------
	logic in_idle;
	logic ram_we;
	logic expanded_ram_we;
	logic [7:0] ram_addr;
	logic [7:0] ram_wdata;
	logic [9:0] expanded_ram_addr;
	logic [9:0] op_xaddr;

	assign in_idle = (state == dmx_pkg::ST_IDLE);
	assign ram_we = (accept && mem_we && !dec_bit && dec_tgt == dmx_pkg::TGT_RAM) ||
		(state == dmx_pkg::ST_READ && op_bit && op_we && op_tgt == dmx_pkg::TGT_RAM);
	assign ram_addr = in_idle ? dec_byte : op_byte;
	assign ram_wdata = in_idle ? mem_wdata : mod_byte;
	assign expanded_ram_we = accept && mem_we && dec_tgt == dmx_pkg::TGT_EXPANDED_RAM;
	assign expanded_ram_addr = in_idle ? dec_xaddr[9:0] : op_xaddr;

	// Hold the expanded RAM address for the read cycle.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			op_xaddr <= 10'h000;
		end else if (accept) begin
			op_xaddr <= dec_xaddr[9:0];
		end
	end

	dmx_ram #(
		.DEPTH(256),
		.AW(8)
	) u_iram (
		.clk(clk),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(ram_wdata),
		.rdata(ram_rdata)
	);

	dmx_ram #(
		.DEPTH(EXPANDED_RAM_DEPTH),
		.AW(10)
	) u_expanded_ram (
		.clk(clk),
		.we(expanded_ram_we),
		.addr(expanded_ram_addr),
		.wdata(mem_wdata),
		.rdata(expanded_ram_rdata)
	);

	// ----------------------------------------------------------------
	// External bus.
	// ----------------------------------------------------------------
	logic ext_start;
	logic [15:0] ext_addr;

	assign ext_start = accept && dec_tgt == dmx_pkg::TGT_EXT;
	assign ext_addr = dec_xaddr; // 8-bit moves carry the latch as high byte.

	dmx_extbus u_ext (
		.clk(clk),
		.rstn(rstn),
		.cpu_ce(cpu_ce),
		.start(ext_start),
		.write(mem_we),
		.stretch(strobe_stretch),
		.addr(ext_addr),
		.wdata(mem_wdata),
		.idle_high(high_port_latch),
		.low_port_in(low_port_in),
		.low_port_out(low_port_out),
		.low_port_oe(low_port_oe),
		.high_port_out(high_port_out),
		.ale(ale),
		.rd_n(rd_n),
		.wr_n(wr_n),
		.done(ext_done),
		.rdata(ext_rdata)
	);

endmodule : dmx_top

`default_nettype wire

/* testbench/dmx_ext_mem.sv */
`timescale 1ns/1ps
`default_nettype none

// External data memory on the multiplexed bus; slow sets its read access time in ns.
module dmx_ext_mem (
	input wire logic clk,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] low_port_out,
	input wire logic low_port_oe,
	input wire logic [7:0] high_port_out,
	output logic [7:0] low_port_in
);
	logic [7:0] mem [int];
	logic [15:0] addr = 16'h0000;
	logic [7:0] last = 8'h00;
	logic [7:0] rdv = 8'h00;
	bit rd_on = 1'b0;
	int slow = 0;

	// Latches the full address while the address strobe is high.
	always @(posedge clk) begin
		if (ale) addr <= {high_port_out, low_port_out};
		if (low_port_oe || rd_on) last <= low_port_in;
	end

	// Answers a read after the access time and lets go when the strobe rises.
	always @(negedge rd_n) begin
		rd_on = 1'b0;
		#(slow);
		rdv = mem.exists(addr) ? mem[addr] : ~addr[7:0];
		rd_on = !rd_n;
	end
	always @(posedge rd_n) rd_on = 1'b0;

	// Stores the data standing on the low port as the write strobe rises.
	always @(posedge wr_n) mem[addr] = low_port_out;

	// A released line shows the inverse of its last level.
	assign low_port_in = low_port_oe ? low_port_out : (rd_on ? rdv : ~last);
endmodule : dmx_ext_mem

`default_nettype wire

/* testbench/dmx_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

// Watches the external bus strobes and the SFR side of the controller.
module dmx_top_asserts (
	input wire logic clk,
	input wire logic rstn,
	input wire logic double_speed_mode,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic low_port_oe,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic mem_done
);
	logic [5:0] low_cnt;

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// Counts the cycles for which a strobe has been low.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			low_cnt <= 6'h00;
		end else begin
			low_cnt <= (!rd_n || !wr_n) ? low_cnt + 6'h01 : 6'h00;
		end
	end

	strobes_exclusive_a: assert property (rd_n || wr_n)
		else $error("read and write strobes low together");
	ale_quiet_a: assert property (ale |-> rd_n && wr_n)
		else $error("address strobe during a data strobe");
	ale_drives_a: assert property (ale |-> low_port_oe)
		else $error("address strobe without low port driven");
	read_release_a: assert property (!rd_n |-> !low_port_oe)
		else $error("low port driven during read strobe");
	write_drive_a: assert property (!wr_n |-> low_port_oe)
		else $error("low port not driven during write strobe");
	strobe_width_a: assert property ($rose(rd_n && wr_n) |-> (double_speed_mode ?
		(low_cnt == 6'h03 || low_cnt == 6'h0F) : (low_cnt == 6'h06 || low_cnt == 6'h1E)))
		else $error("strobe width wrong");
	addr_phase_a: assert property ($fell(ale) |-> ##[1:2] $fell(rd_n && wr_n))
		else $error("data strobe not one period after address strobe");
	strobe_done_a: assert property ($rose(rd_n && wr_n) |-> ##[1:5] mem_done)
		else $error("no completion after strobe");
	sfr_upper_a: assert property (sfr_rd |-> sfr_addr[7])
		else $error("SFR read below 80h");

	read_seen_c: cover property ($fell(rd_n));
	write_seen_c: cover property ($fell(wr_n));
	stretch_seen_c: cover property (low_cnt == 6'h0F);
	sfr_seen_c: cover property (sfr_rd);
endmodule : dmx_top_asserts

bind dmx_top dmx_top_asserts u_dmx_top_asserts (.clk(clk), .rstn(rstn),
	.double_speed_mode(double_speed_mode), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
	.low_port_oe(low_port_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .mem_done(mem_done));

`default_nettype wire

/* testbench/dmx_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dmx_consts.svh"

// Drives core, config and SFR sides and compares against a reference model.
module dmx_top_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ds = 1'b1;
	logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
	logic cfg_we = 1'b0, cfg_re = 1'b0, mem_req = 1'b0, mem_we = 1'b0;
	logic [2:0] mem_kind = 3'h0;
	logic [15:0] mem_addr = 16'h0000;
	logic [7:0] mem_wdata = 8'h00, mem_rdata, sfr_addr, sfr_wdata, sfr_rdata;
	logic mem_busy, mem_done, sfr_rd, sfr_wr, low_port_oe, ale, rd_n, wr_n, ex;
	logic [7:0] low_port_in, low_port_out, high_port_out, sfr_wa, sfr_wd;
	logic [31:0] a;
	int m[int];
	int bank, xdis, xrs, st, hpl, i, j, c;
	int num_errors = 0, tests_run = 0, cyc = 0;

	always #5 clk = ~clk;
	assign sfr_rdata = sfr_addr ^ 8'h3C;

	dmx_top u_dmx_top (.clk(clk), .rstn(rstn), .double_speed_mode(ds), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_we(cfg_we), .cfg_re(cfg_re), .cfg_rdata(cfg_rdata),
		.mem_req(mem_req), .mem_kind(mem_kind), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_busy(mem_busy), .mem_done(mem_done),
		.mem_rdata(mem_rdata), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .low_port_in(low_port_in),
		.low_port_out(low_port_out), .low_port_oe(low_port_oe),
		.high_port_out(high_port_out), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));

	dmx_ext_mem u_dmx_ext_mem (.clk(clk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
		.low_port_out(low_port_out), .low_port_oe(low_port_oe),
		.high_port_out(high_port_out), .low_port_in(low_port_in));

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("mismatches %0d of %0d checks", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop

	// Records SFR writes and cuts a hung run short.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (sfr_wr === 1'b1) sfr_wa <= sfr_addr;
		if (sfr_wr === 1'b1) sfr_wd <= sfr_wdata;
		if (cyc == 60000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic cfg_wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk);
		cfg_we <= 1'b1;
		cfg_addr <= ad;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_we <= 1'b0;
	endtask : cfg_wr

	task automatic cfg_rd(input logic [7:0] ad, input logic [7:0] e);
		@(posedge clk);
		cfg_re <= 1'b1;
		cfg_addr <= ad;
		@(posedge clk);
		cfg_re <= 1'b0;
		#1;
		chk(cfg_rdata, e);
	endtask : cfg_rd

	// Works out the expected result in the model, then runs one core access.
	task automatic acc(input logic [2:0] k, input logic w, input logic [15:0] ad,
		input logic [7:0] d);
		int x;
		int key;
		int e;
		int n;
		bit sfr;
		x = ad[7:0];
		if (k == 3'h2) x = bank * 8 + ad[2:0];
		if (k == 3'h3) x = 32 + ad[6:3];
		if (k == 3'h4) x = ad;
		if (k == 3'h5) x = hpl * 256 + ad[7:0];
		sfr = (k == 3'h0 && x > 127);
		ex = (k > 3'h3 && !(xdis == 0 && x < (xrs + 1) * 256));
		key = (k < 3'h4) ? x : (ex ? 32'h0002_0000 : 32'h0001_0000) + x;
		if (w && !sfr) m[key] = (k == 3'h3) ? (m[key] & ~(1 << ad[2:0])) | (d[0] << ad[2:0]) : d;
		e = sfr ? x ^ 8'h3C : (k == 3'h3) ? (m[key] >> ad[2:0]) & 1 : m[key];
		@(posedge clk);
		mem_req <= 1'b1;
		mem_kind <= k;
		mem_we <= w;
		mem_addr <= ad;
		mem_wdata <= d;
		@(posedge clk);
		mem_req <= 1'b0;
		#1;
		chk({7'h00, mem_busy}, {7'h00, (k == 3'h3 || ex || !w)});
		for (n = 0; n < 200 && mem_done !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 200) chk(8'h00, 8'hFF);
		if (!w) chk((k == 3'h3) ? {7'h00, mem_rdata[0]} : mem_rdata, e[7:0]);
		if (w && sfr) begin
			@(posedge clk);
			#1;
			chk(sfr_wa, x[7:0]);
			chk(sfr_wd, d);
		end
	endtask : acc

	task automatic aux(input int s, input int r, input int dis);
		st = s;
		xrs = r;
		xdis = dis;
		u_dmx_ext_mem.slow = s ? 100 : 0;
		cfg_wr(`DMX_AUXILIARY_CONTROL_REGISTER_ADDR, {2'h0, st[0], 1'b0, xrs[1:0], xdis[0], 1'b0});
	endtask : aux

	initial begin
		void'($urandom(95934));
		bank = 0;
		hpl = 255;
		st = 0;
		xrs = 3;
		xdis = 0;
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		cfg_rd(`DMX_PSW_ADDR, `DMX_PSW_RESET);
		cfg_rd(`DMX_AUXILIARY_CONTROL_REGISTER_ADDR, 8'h0C);
		cfg_rd(`DMX_HPL_ADDR, `DMX_HPL_RESET);
		cfg_rd(8'h12, 8'h00);
		// Lower RAM both ways; upper RAM indirect only, direct goes to SFRs.
		for (i = 0; i < 24; i++) begin
			a = $urandom;
			acc(3'h0, 1'b1, {9'h000, a[6:0]}, a[15:8]);
			acc(3'h1, 1'b0, {9'h000, a[6:0]}, 8'h00);
			acc(3'h1, 1'b1, {9'h001, a[6:0]}, a[23:16]);
			acc(3'h0, a[24], {9'h001, a[6:0]}, a[31:24]);
			acc(3'h1, 1'b0, {9'h001, a[6:0]}, 8'h00);
		end
		// Every bank and every working register.
		for (i = 0; i < 32; i++) begin
			a = $urandom;
			bank = i / 8;
			cfg_wr(`DMX_PSW_ADDR, {3'h0, bank[1:0], 3'h0});
			acc(3'h2, 1'b1, {13'h0000, i[2:0]}, a[7:0]);
			acc(3'h0, 1'b0, {11'h000, i[4:0]}, 8'h00);
		end
		// Bit writes and reads over the whole bit area.
		for (i = 0; i < 16; i++) begin
			a = $urandom;
			acc(3'h0, 1'b1, {8'h00, 8'h20 + i[3:0]}, a[7:0]);
			acc(3'h3, 1'b1, {9'h000, i[3:0], a[10:8]}, {7'h00, a[11]});
			acc(3'h0, 1'b0, {8'h00, 8'h20 + i[3:0]}, 8'h00);
			acc(3'h3, 1'b0, {9'h000, i[3:0], a[14:12]}, 8'h00);
		end
		// External moves over every size, disable, stretch and speed setting.
		for (c = 0; c < 8; c++) begin
			@(posedge clk);
			ds <= c[0];
			aux(c[1], c[1:0], c[2]);
			for (j = 0; j < 4; j++) begin
				a = $urandom;
				acc(3'h4, 1'b1, {5'h00, a[10:0]}, a[23:16]);
				cfg_rd(`DMX_STAT_ADDR, {6'h00, ex, 1'b0});
				acc(3'h4, 1'b0, {5'h00, a[10:0]}, 8'h00);
				hpl = a[31:24];
				cfg_wr(`DMX_HPL_ADDR, hpl[7:0]);
				acc(3'h5, 1'b1, {8'h00, a[7:0]}, a[15:8]);
				acc(3'h4, 1'b0, {hpl[7:0], a[7:0]}, 8'h00);
			end
		end
		// A second reset clears the stretch and disable bits set by the last pass.
		@(posedge clk);
		rstn <= 1'b0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		cfg_rd(`DMX_AUXILIARY_CONTROL_REGISTER_ADDR, 8'h0C);
		report_and_stop();
	end
endmodule : dmx_top_tb

`default_nettype wire
